// >>> inc/pcss_pkg.sv
package pcss_pkg;

    localparam int unsigned PHASE_W = 3;

    // Default event phases and phase limits
    localparam logic [2:0] DEF_RELEASE_PHASE = 3'h4;
    localparam logic [2:0] DEF_TRISTATE_PHASE = 3'h5;
    localparam logic [2:0] DEF_WRITE_PHASE = 3'h6;
    localparam logic [2:0] DEF_LOCK_PHASE = 3'h1;
    localparam logic [2:0] DEF_MATCH_PHASE = 3'h1;
    localparam logic [2:0] FIRST_PROG_PHASE = 3'h1;
    localparam logic [2:0] LAST_PROG_PHASE = 3'h6;
    localparam logic [2:0] FINAL_PHASE = 3'h7;

    // Register offsets
    localparam logic [3:0] CFG_OFFS = 4'h0;
    localparam logic [3:0] CTRL_OFFS = 4'h1;
    localparam logic [3:0] STAT_OFFS = 4'h2;

    // Configuration register fields
    localparam int unsigned CFG_RELEASE_LSB = 0;
    localparam int unsigned CFG_TRISTATE_LSB = 4;
    localparam int unsigned CFG_WRITE_LSB = 8;
    localparam int unsigned CFG_LOCK_LSB = 12;
    localparam int unsigned CFG_MATCH_LSB = 16;
    localparam int unsigned CFG_LOCK_EN_BIT = 20;
    localparam int unsigned CFG_MATCH_EN_BIT = 21;
    localparam int unsigned CFG_DRIVE_BIT = 22;
    localparam logic [31:0] CFG_RESET = 32'h0001_1654;

    // Control register fields
    localparam int unsigned CTRL_FRAMES_BIT = 0;
    localparam int unsigned CTRL_START_BIT = 1;

    // Status register fields
    localparam int unsigned STAT_PHASE_LSB = 0;
    localparam int unsigned STAT_RELEASED_BIT = 4;
    localparam int unsigned STAT_PIN_BIT = 5;
    localparam int unsigned STAT_WRITE_BIT = 6;
    localparam int unsigned STAT_TRISTATE_BIT = 7;
    localparam int unsigned STAT_EOS_BIT = 8;
    localparam int unsigned STAT_MATCH_BIT = 9;
    localparam int unsigned STAT_LOCK_BIT = 10;
    localparam int unsigned STAT_FRAMES_BIT = 11;

    typedef struct packed {
        logic [3:0]  addr;
        logic [31:0] wdata;
        logic        wr;
        logic        rd;
    } pcss_req_t;

    typedef struct packed {
        logic global_write_enable;
        logic global_io_tristate;
        logic end_of_startup;
    } pcss_glob_t;

endpackage

// >>> logic/pcss_sequencer.sv
// Chosen here: the address-and-strobe port and the register addresses.
`timescale 1ns/1ns
// What this block does
// - Startup begins only after frames loaded and a start command arrives.
// - Sequencer steps through eight phases numbered zero to seven.
// - Phase of every event except end-of-startup is software-programmable.
// - Optional stall in a chosen phase 1-6 until clock managers lock.
// - Optional stall in a chosen phase 1-6 until impedance controllers match.
// - Global write enable asserts in a programmable phase from 1 to 6.
// - Global tri-state deasserts in a programmable phase from 1 to 6.
// - End-of-startup always asserts in phase seven.
// - Defaults: release pin phase 4, tri-state off 5, write enable 6.
// - Enabled lock/match waits gate pin release, tri-state and write enable.
// - After pin release, no advance until the pin is sampled High.
// - Completion pin is open-drain by default; active drive is optional.
// - Pin-released flag shows own drive state, not the pin level.
// - Write enable low inhibits all synchronous storage from updating.
// - Tri-state high disables all user I/O drivers.
// - End-of-startup marks complete configuration and startup.
// - Match flag asserts only when every impedance controller matched.
// - Lock flag reads asserted unless a lock wait is in use.
module pcss_sequencer
(
    input  wire logic              sys_clk,
    input  wire logic              srst,
    input  wire pcss_pkg::pcss_req_t bus_req,
    output logic [31:0]            bus_rdata,
    input  wire logic [3:0]        cm_locked,
    input  wire logic [3:0]        ic_matched,
    input  wire logic              done_pin_in,
    output logic                   done_pin_out,
    output logic                   done_pin_oe,
    output pcss_pkg::pcss_glob_t   glob
);
    import pcss_pkg::*;

    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_DONE} pcss_state_t;

    pcss_state_t       state_q;
    logic [2:0]        phase_q;
    logic [31:0]       cfg_q;
    logic              frames_q;
    logic              released_q;
    logic              gwe_q;
    logic              gts_q;
    logic              eos_q;
    logic [2:0]        pin_sync_q;
    logic              pin_high_q;
    logic [31:0]       rdata_q;

    logic [2:0] rel_ph;
    logic [2:0] ts_ph;
    logic [2:0] we_ph;
    logic [2:0] lk_ph;
    logic [2:0] mt_ph;
    logic       lock_en;
    logic       match_en;
    logic       drive_en;
    logic       all_locked;
    logic       all_matched;
    logic       lock_flag;
    logic       stall;
    logic       start_cmd;
    logic       gates_ok;

    assign rel_ph   = cfg_q[CFG_RELEASE_LSB +: 3];
    assign ts_ph    = cfg_q[CFG_TRISTATE_LSB +: 3];
    assign we_ph    = cfg_q[CFG_WRITE_LSB +: 3];
    assign lk_ph    = cfg_q[CFG_LOCK_LSB +: 3];
    assign mt_ph    = cfg_q[CFG_MATCH_LSB +: 3];
    assign lock_en  = cfg_q[CFG_LOCK_EN_BIT];
    assign match_en = cfg_q[CFG_MATCH_EN_BIT];
    assign drive_en = cfg_q[CFG_DRIVE_BIT];

    assign all_locked  = &cm_locked;
    assign all_matched = &ic_matched;
    assign lock_flag   = lock_en ? all_locked : 1'b1;

    assign start_cmd = bus_req.wr && (bus_req.addr == CTRL_OFFS)
                       && bus_req.wdata[CTRL_START_BIT];

    // Waits block the phase they sit in and every later one
    assign gates_ok = (!lock_en || all_locked || phase_q < lk_ph)
                      && (!match_en || all_matched || phase_q < mt_ph);

    always_comb
    begin
        stall = 1'b0;
        if (lock_en && phase_q == lk_ph && !all_locked)
        begin
            stall = 1'b1;
        end
        if (match_en && phase_q == mt_ph && !all_matched)
        begin
            stall = 1'b1;
        end
        // Release phase itself holds, so the step after release waits for the pin
        if ((released_q || (phase_q >= rel_ph && gates_ok)) && !pin_high_q)
        begin
            stall = 1'b1;
        end
    end

    // Configuration; phases outside 1-6 would break ordering, so writes replace them with phase 1
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            cfg_q <= CFG_RESET;
        end
        else if (bus_req.wr && bus_req.addr == CFG_OFFS && state_q == ST_IDLE)
        begin
            cfg_q <= bus_req.wdata;
            for (int i = 0; i < 5; i++)
            begin
                if (bus_req.wdata[4*i +: 3] < FIRST_PROG_PHASE
                    || bus_req.wdata[4*i +: 3] > LAST_PROG_PHASE)
                begin
                    cfg_q[4*i +: 3] <= FIRST_PROG_PHASE;
                end
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            frames_q <= 1'b0;
        end
        else if (bus_req.wr && bus_req.addr == CTRL_OFFS && state_q == ST_IDLE)
        begin
            frames_q <= bus_req.wdata[CTRL_FRAMES_BIT];
        end
    end

    // Pin level passes three flops; change counts when last two agree
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            pin_sync_q <= 3'h0;
            pin_high_q <= 1'b0;
        end
        else
        begin
            pin_sync_q <= {pin_sync_q[1:0], done_pin_in};
            if (pin_sync_q[2] == pin_sync_q[1])
            begin
                pin_high_q <= pin_sync_q[2];
            end
        end
    end

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            state_q <= ST_IDLE;
            phase_q <= 3'h0;
        end
        else
        begin
            unique case (state_q)
                ST_IDLE:
                begin
                    if (start_cmd && frames_q)
                    begin
                        state_q <= ST_RUN;
                    end
                end
                ST_RUN:
                begin
                    if (phase_q == FINAL_PHASE)
                    begin
                        state_q <= ST_DONE;
                    end
                    else if (!stall)
                    begin
                        phase_q <= phase_q + 3'h1;
                    end
                end
                ST_DONE:
                begin
                    state_q <= ST_DONE;
                end
            endcase
        end
    end

    // Events latch once their phase is reached; all but end-of-startup also wait for gates to allow
    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            released_q <= 1'b0;
            gwe_q      <= 1'b0;
            gts_q      <= 1'b1;
            eos_q      <= 1'b0;
        end
        else if (state_q == ST_RUN)
        begin
            if (phase_q >= rel_ph && gates_ok)
            begin
                released_q <= 1'b1;
            end
            if (phase_q >= ts_ph && gates_ok)
            begin
                gts_q <= 1'b0;
            end
            if (phase_q >= we_ph && gates_ok)
            begin
                gwe_q <= 1'b1;
            end
            if (phase_q == FINAL_PHASE)
            begin
                eos_q <= 1'b1;
            end
        end
    end

    // Write enable low holds fabric storage; tri-state high holds user I/O off
    assign glob.global_write_enable = gwe_q;
    assign glob.global_io_tristate  = gts_q;
    assign glob.end_of_startup      = eos_q;

    // Open-drain: drive Low until released; active drive pushes High after
    assign done_pin_out = released_q;
    assign done_pin_oe  = !released_q || drive_en;

    always_ff @(posedge sys_clk)
    begin
        if (srst)
        begin
            rdata_q <= 32'h0000_0000;
        end
        else if (bus_req.rd)
        begin
            rdata_q <= 32'h0000_0000;
            unique case (bus_req.addr)
                CFG_OFFS:  rdata_q <= cfg_q;
                CTRL_OFFS: rdata_q[CTRL_FRAMES_BIT] <= frames_q;
                STAT_OFFS:
                begin
                    rdata_q[STAT_PHASE_LSB +: 3] <= phase_q;
                    rdata_q[STAT_RELEASED_BIT]   <= released_q;
                    rdata_q[STAT_PIN_BIT]        <= pin_high_q;
                    rdata_q[STAT_WRITE_BIT]      <= gwe_q;
                    rdata_q[STAT_TRISTATE_BIT]   <= gts_q;
                    rdata_q[STAT_EOS_BIT]        <= eos_q;
                    rdata_q[STAT_MATCH_BIT]      <= all_matched;
                    rdata_q[STAT_LOCK_BIT]       <= lock_flag;
                    rdata_q[STAT_FRAMES_BIT]     <= frames_q;
                end
                default: rdata_q <= 32'h0000_0000;
            endcase
        end
    end

    assign bus_rdata = rdata_q;

    sequence s_pin_seen;
        pin_high_q;
    endsequence

    a_eos_phase7: assert property (@(posedge sys_clk) disable iff (srst)
        eos_q |-> phase_q == FINAL_PHASE)
        else $error("end of startup outside final phase");

    a_start_gate: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(state_q == ST_RUN) |-> $past(frames_q) && $past(start_cmd))
        else $error("startup began without frames and command");

    a_step_one: assert property (@(posedge sys_clk) disable iff (srst)
        phase_q != $past(phase_q) |-> phase_q == $past(phase_q) + 3'h1
        && !$past(stall))
        else $error("phase skipped or advanced under stall");

    a_pin_hold: assert property (@(posedge sys_clk) disable iff (srst)
        released_q && !pin_high_q && state_q == ST_RUN |=> $stable(phase_q))
        else $error("advanced before completion pin High");

    a_lock_wait: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_RUN && lock_en && phase_q == lk_ph && !all_locked
        |=> phase_q == lk_ph)
        else $error("left lock wait phase without lock");

    a_match_wait: assert property (@(posedge sys_clk) disable iff (srst)
        state_q == ST_RUN && match_en && phase_q == mt_ph && !all_matched
        |=> phase_q == mt_ph)
        else $error("left match wait phase without match");

    a_gwe_phase: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(gwe_q) |-> $past(phase_q) >= we_ph)
        else $error("write enable before its phase");

    a_gts_phase: assert property (@(posedge sys_clk) disable iff (srst)
        $fell(gts_q) |-> $past(phase_q) >= ts_ph && $past(gates_ok))
        else $error("tri-state released early");

    a_release_od: assert property (@(posedge sys_clk) disable iff (srst)
        !released_q |-> done_pin_oe && !done_pin_out)
        else $error("completion pin not driven Low before release");

    a_final_pin: assert property (@(posedge sys_clk) disable iff (srst)
        $rose(eos_q) |-> s_pin_seen)
        else $error("final phase reached without pin High");

endmodule

// >>> test/pcss_pin_partner.sv
`timescale 1ns/1ns
module pcss_pin_partner
(
    input  wire logic drv_oe,
    input  wire logic drv_out,
    input  wire logic hold_low,
    output logic      pin_level
);
    // Pull-up wins unless some party sinks the line; contention reads low
    assign pin_level = ((drv_oe && !drv_out) || hold_low) ? 1'b0 : 1'b1;
endmodule

// >>> test/test_post_config_startup_sequencer.sv
`timescale 1ns/1ns
module test_post_config_startup_sequencer;
    import pcss_pkg::*;
    logic        sys_clk;
    logic        srst;
    pcss_req_t   req;
    logic [31:0] rdata;
    logic [3:0]  cm;
    logic [3:0]  ic;
    logic        pin;
    logic        dout;
    logic        oe;
    logic        hold_low;
    pcss_glob_t  glob;
    int          error_cnt;
    int          total_checks;
    int          cyc;
    int          t[4];
    integer      seed;
    logic [31:0] st;
    logic [2:0]  pa;
    logic [2:0]  pb;
    logic [2:0]  pc;

    pcss_sequencer u_pcss_sequencer (.sys_clk(sys_clk), .srst(srst), .bus_req(req),
        .bus_rdata(rdata), .cm_locked(cm), .ic_matched(ic), .done_pin_in(pin),
        .done_pin_out(dout), .done_pin_oe(oe), .glob(glob));
    pcss_pin_partner u_pcss_pin_partner (.drv_oe(oe), .drv_out(dout), .hold_low(hold_low),
        .pin_level(pin));

    initial
    begin
        sys_clk = 1'b0;
        forever #20 sys_clk = ~sys_clk;
    end

    always @(posedge sys_clk) cyc <= cyc + 1;

    // First cycle of each event, sampled mid-cycle once settled
    always @(negedge sys_clk)
    begin
        if (t[0] < 0 && !(oe && !dout)) t[0] = cyc;
        if (t[1] < 0 && !glob.global_io_tristate) t[1] = cyc;
        if (t[2] < 0 && glob.global_write_enable) t[2] = cyc;
        if (t[3] < 0 && glob.end_of_startup) t[3] = cyc;
    end

    task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("unexpected %s: expected %h seen %h", nm, exp, seen);
        end
    endtask

    task close_out;
        $display("checks %0d errors %0d", total_checks, error_cnt);
        if (error_cnt == 0 && total_checks > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask

    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge sys_clk);
        req <= '{a, d, 1'b1, 1'b0};
        @(posedge sys_clk);
        req.wr <= 1'b0;
    endtask

    task rd(input logic [3:0] a);
        @(posedge sys_clk);
        req <= '{a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge sys_clk);
        req.rd <= 1'b0;
        @(negedge sys_clk);
        st = rdata;
    endtask

    task rst;
        srst <= 1'b1;
        repeat (6) @(posedge sys_clk);
        srst <= 1'b0;
        t = '{-1, -1, -1, -1};
    endtask

    task automatic wait_ev(input int i);
        int k;
        for (k = 0; k < 300 && t[i] < 0; k++)
            @(posedge sys_clk);
        chk("event timeout", t[i] < 0, 0);
        if (t[i] < 0)
            close_out;
    endtask

    // Pin stall only separates events on opposite sides of the release phase
    task automatic pair(input int ta, input int p1, input int tb, input int p2, input int rel);
        int d;
        int g;
        d = (p1 < p2) ? tb - ta : ta - tb;
        g = (p1 < p2) ? p2 - p1 : p1 - p2;
        if ((p1 > rel) == (p2 > rel))
            chk("event gap", d, g);
        else
            chk("stall gap", d > g, 1);
    endtask

    task automatic run(input logic [31:0] cfg, input int hold);
        logic [2:0] rp;
        rp = cfg[2:0];
        rst;
        chk("reset outputs", {glob, oe, dout}, 5'b01010);
        rd(CFG_OFFS);
        chk("cfg reset", st, CFG_RESET);
        wr(4'hF, 32'hFFFF_FFFF);
        rd(4'hF);
        chk("unmapped", st, 32'h0000_0000);
        wr(CTRL_OFFS, 32'h0000_0002);
        repeat (4) @(posedge sys_clk);
        rd(STAT_OFFS);
        chk("idle stat", st[11:0], {2'b01, &ic, 9'h080});
        wr(CFG_OFFS, cfg);
        rd(CFG_OFFS);
        chk("cfg", st, cfg);
        hold_low <= (hold > 0);
        wr(CTRL_OFFS, 32'h0000_0001);
        wr(CTRL_OFFS, 32'h0000_0003);
        if (cfg[20])
        begin
            repeat (20) @(posedge sys_clk);
            rd(STAT_OFFS);
            chk("lock stall", {st[10], st[7:4], st[2:0]}, {5'b01000, cfg[14:12]});
            cm <= 4'hF;
        end
        if (cfg[21])
        begin
            repeat (20) @(posedge sys_clk);
            rd(STAT_OFFS);
            chk("match stall", {st[9], st[7:4], st[2:0]}, {5'b01000, cfg[18:16]});
            ic <= 4'hF;
        end
        wait_ev(0);
        chk("pin drive", oe, cfg[22]);
        if (hold > 0)
        begin
            repeat (hold) @(posedge sys_clk);
            rd(STAT_OFFS);
            chk("held stat", {st[8], st[5:4], st[2:0]}, {3'b001, rp});
            hold_low <= 1'b0;
        end
        wait_ev(3);
        pair(t[0], rp, t[1], cfg[6:4], rp);
        pair(t[0], rp, t[2], cfg[10:8], rp);
        pair(t[1], cfg[6:4], t[2], cfg[10:8], rp);
        pair(t[1], cfg[6:4], t[3], 7, rp);
        pair(t[2], cfg[10:8], t[3], 7, rp);
        wr(CFG_OFFS, 32'h0000_0000);
        rd(CFG_OFFS);
        chk("cfg after start", st, cfg);
        rd(STAT_OFFS);
        chk("end stat", {st[11:4], st[2:0]}, {1'b1, !cfg[20] || &cm, &ic, 5'h17, 3'h7});
    endtask

    initial
    begin
        srst = 1'b1;
        req = '0;
        cm = 4'hF;
        ic = 4'hF;
        hold_low = 1'b0;
        cyc = 0;
        error_cnt = 0;
        total_checks = 0;
        seed = 87918;
        t = '{-1, -1, -1, -1};
        run(CFG_RESET, 0);
        run(CFG_RESET, 12);
        @(posedge sys_clk);
        cm <= 4'(8'h07 & $random(seed));
        ic <= 4'(8'h0B & $random(seed));
        run(32'h0073_2654, 5);
        rst;
        wr(CFG_OFFS, 32'h0000_0070);
        rd(CFG_OFFS);
        chk("cfg clamp", st, 32'h0001_1111);
        repeat (5)
        begin
            @(posedge sys_clk);
            cm <= 4'($random(seed));
            ic <= 4'($random(seed));
            pa = 3'(1 + {$random(seed)} % 5);
            pb = 3'(1 + {$random(seed)} % 6);
            pc = 3'(1 + {$random(seed)} % 6);
            run(32'h0001_1000 | {21'h0_0000, pc, 1'b0, pb, 1'b0, pa}, {$random(seed)} % 16);
        end
        close_out;
    end
endmodule
